//--- hdl/zrw_pkg.sv
// zone read timing package: register layout, reset values, phase codes
// assumes a single 20 MHz clock domain serving as the interface timing clock
package zrw_pkg;
    // timing register word layout
    localparam int ZRW_DOUBLE_BIT     = 22;
    localparam int ZRW_RDY_ASYNC_BIT  = 15;
    localparam int ZRW_RDY_USE_BIT    = 14;
    localparam int ZRW_LEAD_HI        = 13;
    localparam int ZRW_LEAD_LO        = 12;
    localparam int ZRW_ACT_HI         = 11;
    localparam int ZRW_ACT_LO         = 9;
    localparam int ZRW_TRAIL_HI       = 8;
    localparam int ZRW_TRAIL_LO       = 7;

    // register offsets (word index on the plain port)
    localparam logic [3:0] ZRW_ADDR_TIMING = 4'h0;
    localparam logic [3:0] ZRW_ADDR_STATUS = 4'h1;
    localparam logic [3:0] ZRW_ADDR_CMD    = 4'h2;

    // reset value: doubling on, async ready, ready used, all counts at max
    localparam logic [31:0] ZRW_TIMING_RESET = 32'h0040_FF80;
    localparam logic [31:0] ZRW_TIMING_MASK  = 32'h0040_FF80;

    localparam logic [1:0] ZRW_LEAD_INVALID = 2'h0;
    localparam logic [4:0] ZRW_ONE          = 5'h01;
    localparam logic [4:0] ZRW_ZERO         = 5'h00;

    typedef enum logic [2:0] {
        ZRW_IDLE  = 3'b000,
        ZRW_LEAD  = 3'b001,
        ZRW_ACT   = 3'b010,
        ZRW_WAIT  = 3'b011,
        ZRW_TRAIL = 3'b100
    } zrw_phase_e;

    // decoded per-zone timing setup
    typedef struct packed {
        logic       dbl;
        logic       rdy_async;
        logic       rdy_use;
        logic [1:0] lead;
        logic [2:0] act;
        logic [1:0] trail;
    } zrw_cfg_s;
endpackage

//--- hdl/zrw_ctrl.sv
// zone read wait-state sequencer with its timing register and plain port
// assumes clk is the timing clock; ext_ready_in is an asynchronous pin
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - ready-sampling select 1 means ready input asynchronous; that is reset value.
// - ready-use bit 0 makes reads ignore the ready input entirely.
// - ready-use 1 lets low ready stretch active phase beyond programmed minimum.
// - lead field bits 13:12 sets lead cycles, doubled by doubling bit.
// - lead 00 invalid; 01,10,11 give 1,2,3 cycles, doubled 2,4,6.
// - active field bits 11:9 adds waits to one base cycle, waits doubled.
// - active code n adds n cycles times the scaling factor.
// - doubling bit 22 scales lead, active, trail waits by two; set after reset.
// - sampling select has no effect while ready-use bit is 0.
module zrw_ctrl
    import zrw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        ext_ready_in,
    output logic             rd_strobe_n,
    output logic             cs_n,
    output logic             busy
);
    zrw_phase_e  phase_reg, phase_next;
    logic [4:0]  cnt_reg, cnt_next;
    logic [31:0] timing_reg, timing_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        start_reg, start_next;
    logic        err_reg, err_next;
    logic        rdy_m_reg, rdy_s_reg, rdy_d_reg;
    logic        rd_n_reg, rd_n_next, cs_n_reg, cs_n_next;
    zrw_cfg_s    cfg;
    logic        ready_ok;
    logic        busy_reg, busy_next;
    logic [4:0]  trail_len, done_cnt;
    zrw_phase_e  done_phase;
    logic        done_cs_n;

    // scale a wait count by the doubling factor
    function automatic logic [4:0] zrw_scale(input logic [2:0] n, input logic dbl);
        zrw_scale = dbl ? {1'b0, n, 1'b0} : {2'b00, n};
    endfunction

    assign cfg = '{dbl:       timing_reg[ZRW_DOUBLE_BIT],
                   rdy_async: timing_reg[ZRW_RDY_ASYNC_BIT],
                   rdy_use:   timing_reg[ZRW_RDY_USE_BIT],
                   lead:      timing_reg[ZRW_LEAD_HI:ZRW_LEAD_LO],
                   act:       timing_reg[ZRW_ACT_HI:ZRW_ACT_LO],
                   trail:     timing_reg[ZRW_TRAIL_HI:ZRW_TRAIL_LO]};

    // ready pin synchroniser plus one extra stage for async mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdy_m_reg <= 1'b1;
            rdy_s_reg <= 1'b1;
            rdy_d_reg <= 1'b1;
        end else begin
            rdy_m_reg <= ext_ready_in;
            rdy_s_reg <= rdy_m_reg;
            rdy_d_reg <= rdy_s_reg;
        end
    end

    // async mode qualifies ready over two samples to reject a glitch
    // limitation: the pin is seen two or three clocks late, so a memory
    // must drop ready that early before the last programmed active cycle
    always_comb begin
        if (!cfg.rdy_use) begin
            ready_ok = 1'b1;
        end else if (cfg.rdy_async) begin
            ready_ok = rdy_s_reg & rdy_d_reg;
        end else begin
            ready_ok = rdy_s_reg;
        end
    end

    // target once the active phase is released; a zero trail skips straight
    // to idle so that code 00 really costs no cycle of select
    always_comb begin
        trail_len = zrw_scale({1'b0, cfg.trail}, cfg.dbl);
        if (trail_len == ZRW_ZERO) begin
            done_phase = ZRW_IDLE;
            done_cnt   = ZRW_ZERO;
            done_cs_n  = 1'b1;
        end else begin
            done_phase = ZRW_TRAIL;
            done_cnt   = trail_len - ZRW_ONE;
            done_cs_n  = 1'b0;
        end
    end

    // register port: timing word, status, start command
    always_comb begin
        timing_next = timing_reg;
        start_next  = 1'b0;
        rdata_next  = 32'h0000_0000;
        err_next    = err_reg;
        if (reg_wr) begin
            unique case (reg_addr)
                ZRW_ADDR_TIMING: timing_next = reg_wdata & ZRW_TIMING_MASK;
                ZRW_ADDR_CMD:    start_next  = reg_wdata[0];
                default:         timing_next = timing_reg;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ZRW_ADDR_TIMING: rdata_next = timing_reg;
                ZRW_ADDR_STATUS: rdata_next = {27'h0, err_reg, rdy_s_reg,
                                               phase_reg};
                default:         rdata_next = 32'h0000_0000;
            endcase
            if (reg_addr == ZRW_ADDR_STATUS) begin
                err_next = 1'b0;
            end
        end
        // a fresh invalid-lead event beats the read clear
        if (phase_reg == ZRW_IDLE && start_reg && cfg.lead == ZRW_LEAD_INVALID) begin
            err_next = 1'b1;
        end
    end

    // read sequencer: lead, active, ready wait, trail
    always_comb begin
        phase_next = phase_reg;
        cnt_next   = cnt_reg;
        rd_n_next  = 1'b1;
        cs_n_next  = 1'b1;
        unique case (phase_reg)
            ZRW_IDLE: begin
                if (start_reg && cfg.lead != ZRW_LEAD_INVALID) begin
                    phase_next = ZRW_LEAD;
                    cnt_next   = zrw_scale({1'b0, cfg.lead}, cfg.dbl) - ZRW_ONE;
                    cs_n_next  = 1'b0;
                end
            end
            ZRW_LEAD: begin
                cs_n_next = 1'b0;
                if (cnt_reg == ZRW_ZERO) begin
                    phase_next = ZRW_ACT;
                    cnt_next   = zrw_scale(cfg.act, cfg.dbl);
                    rd_n_next  = 1'b0;
                end else begin
                    cnt_next = cnt_reg - ZRW_ONE;
                end
            end
            ZRW_ACT: begin
                cs_n_next = 1'b0;
                rd_n_next = 1'b0;
                // ready is judged in the last programmed cycle, so an idle
                // memory costs no extra cycle beyond one plus the waits
                if (cnt_reg != ZRW_ZERO) begin
                    cnt_next = cnt_reg - ZRW_ONE;
                end else if (ready_ok) begin
                    phase_next = done_phase;
                    cnt_next   = done_cnt;
                    cs_n_next  = done_cs_n;
                    rd_n_next  = 1'b1;
                end else begin
                    phase_next = ZRW_WAIT;
                end
            end
            ZRW_WAIT: begin
                cs_n_next = 1'b0;
                rd_n_next = 1'b0;
                if (ready_ok) begin
                    phase_next = done_phase;
                    cnt_next   = done_cnt;
                    cs_n_next  = done_cs_n;
                    rd_n_next  = 1'b1;
                end
            end
            ZRW_TRAIL: begin
                if (cnt_reg == ZRW_ZERO) begin
                    phase_next = ZRW_IDLE;
                end else begin
                    cnt_next  = cnt_reg - ZRW_ONE;
                    cs_n_next = 1'b0;
                end
            end
            default: phase_next = ZRW_IDLE;
        endcase
        // busy is registered so the pin has no decode glitch
        busy_next = (phase_next != ZRW_IDLE);
    end

    // state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timing_reg <= ZRW_TIMING_RESET;
            rdata_reg  <= 32'h0000_0000;
            start_reg  <= 1'b0;
            err_reg    <= 1'b0;
            phase_reg  <= ZRW_IDLE;
            cnt_reg    <= 5'h00;
            rd_n_reg   <= 1'b1;
            cs_n_reg   <= 1'b1;
            busy_reg   <= 1'b0;
        end else begin
            timing_reg <= timing_next;
            rdata_reg  <= rdata_next;
            start_reg  <= start_next;
            err_reg    <= err_next;
            phase_reg  <= phase_next;
            cnt_reg    <= cnt_next;
            rd_n_reg   <= rd_n_next;
            cs_n_reg   <= cs_n_next;
            busy_reg   <= busy_next;
        end
    end

    assign reg_rdata   = rdata_reg;
    assign rd_strobe_n = rd_n_reg;
    assign cs_n        = cs_n_reg;
    assign busy        = busy_reg;
endmodule

`default_nettype wire

//--- bench/zrw_monitor.sv
// pin and port checker for the read sequencer
// assumes bound onto zrw_ctrl, one clock domain
`timescale 1ns/100ps
`default_nettype none
module zrw_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd_strobe_n,
    input wire logic cs_n,
    input wire logic busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // phase ordering and bounds; stretch bound relies on the model's stall limit
    AST_STROBE_IN_CS: assert property (!rd_strobe_n |-> !cs_n)
        else $error("strobe outside select");
    AST_CS_IN_BUSY: assert property (!cs_n |-> busy)
        else $error("select while idle");
    AST_LEAD_FIRST: assert property ($fell(cs_n) |-> rd_strobe_n)
        else $error("no lead phase");
    AST_LEAD_MIN: assert property ($fell(rd_strobe_n) |-> $past(cs_n) == 1'b0)
        else $error("strobe without lead");
    AST_ACT_BOUND: assert property ($fell(rd_strobe_n) |-> ##[1:60] rd_strobe_n)
        else $error("active phase hung");
    AST_TRAIL_BOUND: assert property ($rose(rd_strobe_n) |-> ##[0:6] cs_n)
        else $error("trail too long");
    AST_IDLE_AFTER: assert property ($fell(busy) |-> cs_n && rd_strobe_n)
        else $error("pins active after end");
    AST_ONE_STROBE: assert property ($rose(rd_strobe_n) |-> rd_strobe_n[*3])
        else $error("second strobe too soon");
    AST_CS_SPAN: assert property ($fell(cs_n) |-> ##[2:90] $rose(cs_n))
        else $error("select span wrong");
endmodule
bind zrw_ctrl zrw_monitor u_mon (.clk(clk), .rst_n(rst_n), .rd_strobe_n(rd_strobe_n),
    .cs_n(cs_n), .busy(busy));
`default_nettype wire

//--- bench/zrw_mem_model.sv
// external memory stand-in: holds ready low for a set count per select
// assumes active-low select and strobe, ready high means ready
`timescale 1ns/100ps
`default_nettype none
module zrw_mem_model (
    input  wire logic       clk,
    input  wire logic       cs_n,
    input  wire logic [3:0] stall,
    output logic            ext_ready_in
);
    logic [3:0] hold_reg = 4'h0;
    logic       sel_d_reg = 1'b1;
    logic       last_reg = 1'b1;
    logic       stall_now;
    // ready drops at once when selected and stays low for stall cycles
    assign stall_now = (sel_d_reg && stall != 4'h0) || (hold_reg != 4'h0);
    always @(posedge clk) begin
        sel_d_reg <= cs_n;
        if (!cs_n) last_reg <= !stall_now;
        if (sel_d_reg && !cs_n && stall != 4'h0) hold_reg <= stall - 4'h1;
        else if (hold_reg != 4'h0) hold_reg <= hold_reg - 4'h1;
    end
    // no pull-up assumed, so a deselected pin shows the inverse of its last level
    assign ext_ready_in = cs_n ? !last_reg : !stall_now;
endmodule
`default_nettype wire

//--- bench/zone_read_wait_state_timing_tb_top.sv
// top bench: register port tasks, timed reads against the memory model
// assumes zrw_ctrl, zrw_monitor and zrw_mem_model compiled first
`timescale 1ns/100ps
`default_nettype none
module zone_read_wait_state_timing_tb_top;
    import zrw_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0, stall = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    logic ext_ready_in, rd_strobe_n, cs_n, busy;
    int num_errors = 0, n_checks = 0, l, a, t;
    zrw_ctrl u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_ready_in(ext_ready_in),
        .rd_strobe_n(rd_strobe_n), .cs_n(cs_n), .busy(busy));
    zrw_mem_model u_mem (.clk(clk), .cs_n(cs_n), .stall(stall),
        .ext_ready_in(ext_ready_in));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [3:0] ad);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    function automatic logic [31:0] mk(bit d, bit s, bit u, bit [1:0] ld, bit [2:0] ac,
        bit [1:0] tr);
        return {9'h0, d, 6'h0, s, u, ld, ac, tr, 7'h0};
    endfunction
    // program, start, then count lead, active and trail cycles
    task automatic go(bit d, bit s, bit u, int ld, int ac, int tr, logic [3:0] st);
        int m, b;
        m = d ? 2 : 1;
        b = 0;
        stall <= st;
        wr(ZRW_ADDR_TIMING, mk(d, s, u, ld[1:0], ac[2:0], tr[1:0]));
        wr(ZRW_ADDR_CMD, 32'h1);
        l = 0; a = 0; t = 0;
        repeat (120) begin
            @(posedge clk);
            #1;
            if (busy) b++;
            if (!cs_n && !rd_strobe_n) a++;
            else if (!cs_n && a == 0) l++;
            else if (!cs_n) t++;
        end
        if (ld == 0) return;
        chk("lead", l, ld * m);
        if (st == 4'h0 || !u) chk("active", a, 1 + ac * m);
        else chk("stretch", a > 1 + ac * m, 1);
        chk("trail", t, tr * m);
        chk("busy", b, l + a + t);
    endtask
    initial begin
        #(50 * 4000);
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(ZRW_ADDR_TIMING);
        chk("reset", v, mk(1, 1, 1, 3, 7, 3));
        go(1, 1, 1, 3, 7, 3, 4'h0);
        go(0, 0, 1, 1, 1, 0, 4'h0);
        go(1, 0, 1, 2, 2, 1, 4'h0);
        go(0, 1, 1, 3, 3, 2, 4'h0);
        go(0, 0, 0, 1, 0, 1, 4'h8);
        go(0, 1, 0, 1, 0, 1, 4'h8);
        go(0, 0, 1, 2, 1, 1, 4'h8);
        go(1, 1, 1, 2, 1, 1, 4'h8);
        go(1, 1, 1, 0, 1, 1, 4'h0);
        chk("no access", a + l + t, 0);
        rd(ZRW_ADDR_STATUS);
        chk("err", v[4], 1);
        rd(ZRW_ADDR_STATUS);
        chk("err clear", v[4], 0);
        stop_test();
    end
endmodule
`default_nettype wire
